// >>> rtl/sysctl_regs.sv
// system control registers: memory interface setup, sleep, reset flags, pin interrupts
//
// Notes on behaviour
// - latch wait states in bits 7:6
// - latch waveform mode in bits 5:4
// - interface mode, high bit 0, low bit 1
// - sleep instruction acts only when permitted
// - shallow sleep stops only the core clock
// - deep sleep stops the oscillator too
// - wake on enabled pin interrupt, or usb activity while usb core active
// - tap activity moves deep sleep to stand-by
// - power-on sets power-on flag
// - pin reset sets its flag; both writable
// - watchdog reset leaves both flags alone
// - polarity bits 7:4, cleared means active high
// - pin interrupt needs own and global enable
// - global enable cleared on entry, set on return
`include "sysctl_cfg.svh"
module sysctl_regs
	import sysctl_pkg::*;
(
	input  wire logic                 SYS_CLK,
	input  wire logic                 ARST_N,
	input  wire logic [`ADDR_W-1:0]   ADDR,
	input  wire logic [7:0]           WDATA,
	input  wire logic                 WR_STB,
	input  wire logic                 RD_STB,
	output logic      [7:0]           RDATA,
	input  wire logic                 SLEEP_INSN,
	input  wire logic                 IRQ_TAKEN,
	input  wire logic                 RETURN_FROM_IRQ_INSTRUCTION,
	input  wire logic                 PIN_RESET_SEEN,
	input  wire logic                 WATCHDOG_RESET_SEEN,
	input  wire logic [3:0]           PIN_IRQ,
	input  wire logic                 USB_CORE_ACTIVE,
	input  wire logic                 USB_BUS_ACTIVITY,
	input  wire logic                 TAP_ACTIVITY,
	output logic      [1:0]           LATCH_WAIT,
	output logic      [1:0]           LATCH_WAVEFORM,
	output logic      [1:0]           MEM_IF_MODE,
	output logic      [1:0]           SLEEP_STATE,
	output logic                      CORE_CLK_STOP,
	output logic                      OSC_STOP,
	output logic                      GLOBAL_IE,
	output logic      [3:0]           PIN_IRQ_REQ,
	output logic                      IRQ
);
	logic       rst_meta_r;
	logic       rst_n;
	state_s     st_r;
	state_s     st_nxt;
	logic [3:0] pin_active;
	logic [3:0] pin_enabled;
	logic       wake;
	logic       wr_hit_emc;
	logic       wr_hit_slp;
	logic       wr_hit_rst;
	logic       wr_hit_eim;
	logic       wr_hit_ist;
	logic       wr_hit_imk;
	logic       wr_hit_gie;

	// reset release through two flops
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	assign wr_hit_emc = WR_STB && (ADDR == `OFS_EXT_MEM_CTRL);
	assign wr_hit_slp = WR_STB && (ADDR == `OFS_SLEEP_CTRL);
	assign wr_hit_rst = WR_STB && (ADDR == `OFS_RESET_SRC);
	assign wr_hit_eim = WR_STB && (ADDR == `OFS_EXT_IRQ_MASK);
	assign wr_hit_ist = WR_STB && (ADDR == `OFS_IRQ_STATUS);
	assign wr_hit_imk = WR_STB && (ADDR == `OFS_IRQ_MASK);
	assign wr_hit_gie = WR_STB && (ADDR == `OFS_CORE_STATUS);

	// per-pin polarity and enable gating, with its checks
	for (genvar i = 0; i < 4; i++) begin : g_pin
		assign pin_active[i]  = st_r.irq_polarity[i] ? !PIN_IRQ[i] : PIN_IRQ[i];
		assign pin_enabled[i] = pin_active[i] && st_r.pin_irq_enable[i]
		                        && st_r.global_ie;

		AST_PIN_HIGH: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
			!st_r.irq_polarity[i] && PIN_IRQ[i] &&
			st_r.pin_irq_enable[i] && st_r.global_ie |=> PIN_IRQ_REQ[i])
			else $error("active high pin request missed");
		AST_PIN_LOW: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
			st_r.irq_polarity[i] && !PIN_IRQ[i] &&
			st_r.pin_irq_enable[i] && st_r.global_ie |=> PIN_IRQ_REQ[i])
			else $error("active low pin request missed");
		AST_PIN_IDLE_LVL: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
			(PIN_IRQ[i] == st_r.irq_polarity[i]) |=> !PIN_IRQ_REQ[i])
			else $error("pin request at inactive level");
		AST_PIN_GATE: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
			!(st_r.pin_irq_enable[i] && st_r.global_ie) |=> !PIN_IRQ_REQ[i])
			else $error("pin request without both enables");
		AST_PIN_STICKY: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
			PIN_IRQ_REQ[i] |-> st_r.irq_status[i])
			else $error("pin event not held in status");
		AST_PIN_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
			wr_hit_ist && WDATA[i] && !pin_enabled[i] |=> !st_r.irq_status[i])
			else $error("status bit not cleared by write of one");
	end
	assign wake        = (|pin_enabled) || (USB_CORE_ACTIVE && USB_BUS_ACTIVITY);

	always_comb begin
		st_nxt = st_r;
		// register writes
		if (wr_hit_emc) begin
			st_nxt.ext_mem_ctrl = WDATA;
		end
		if (wr_hit_slp) begin
			st_nxt.sleep_permit       = WDATA[`BIT_SLEEP_PERMIT];
			st_nxt.sleep_depth_select = WDATA[`BIT_SLEEP_DEPTH];
		end
		if (wr_hit_eim) begin
			st_nxt.irq_polarity   = WDATA[7:4];
			st_nxt.pin_irq_enable = WDATA[3:0];
		end
		if (wr_hit_imk) begin
			st_nxt.irq_mask = WDATA[`IRQ_EVT_W-1:0];
		end
		// reset flags: software writes, pin reset sets and wins
		if (wr_hit_rst) begin
			st_nxt.power_on_flag  = WDATA[`BIT_POWER_ON_FLAG];
			st_nxt.pin_reset_flag = WDATA[`BIT_PIN_RESET_FLAG];
		end
		if (PIN_RESET_SEEN) begin
			st_nxt.pin_reset_flag = 1'b1;
		end
		// watchdog reset touches neither flag
		// global enable: write, cleared on entry, set on return
		if (wr_hit_gie) begin
			st_nxt.global_ie = WDATA[`BIT_GLOBAL_IE];
		end
		if (IRQ_TAKEN) begin
			st_nxt.global_ie = 1'b0;
		end
		if (RETURN_FROM_IRQ_INSTRUCTION) begin
			st_nxt.global_ie = 1'b1;
		end
		st_nxt.pin_irq_req = pin_enabled;
		// sleep sequencing
		case (st_r.sleep)
			SLP_AWAKE: begin
				if (SLEEP_INSN && st_r.sleep_permit) begin
					st_nxt.sleep = st_r.sleep_depth_select ? SLP_POWER_DOWN
					                                       : SLP_IDLE;
				end
			end
			SLP_POWER_DOWN: begin
				if (wake) begin
					st_nxt.sleep = SLP_AWAKE;
				end else if (TAP_ACTIVITY) begin
					st_nxt.sleep = SLP_STANDBY;
				end
			end
			SLP_IDLE, SLP_STANDBY: begin
				if (wake) begin
					st_nxt.sleep = SLP_AWAKE;
				end
			end
			default: begin
				st_nxt.sleep = SLP_AWAKE;
			end
		endcase
		// sticky events, write one to clear, set wins
		if (wr_hit_ist) begin
			st_nxt.irq_status = st_r.irq_status & ~WDATA[`IRQ_EVT_W-1:0];
		end
		st_nxt.irq_status[3:0] = st_nxt.irq_status[3:0] | pin_enabled;
		if (st_r.sleep != SLP_AWAKE && st_nxt.sleep == SLP_AWAKE) begin
			st_nxt.irq_status[`IRQ_EVT_WAKE] = 1'b1;
		end
		if (st_r.sleep == SLP_POWER_DOWN && st_nxt.sleep == SLP_STANDBY) begin
			st_nxt.irq_status[`IRQ_EVT_STANDBY] = 1'b1;
		end
		// read data, one cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (RD_STB) begin
			case (ADDR)
				`OFS_EXT_MEM_CTRL: st_nxt.rdata = st_r.ext_mem_ctrl;
				`OFS_RESET_SRC:    st_nxt.rdata = {6'h00, st_r.pin_reset_flag,
				                                   st_r.power_on_flag};
				`OFS_SLEEP_CTRL:   st_nxt.rdata = {1'b0, st_r.sleep_permit,
				                                   st_r.sleep_depth_select, 5'h00};
				`OFS_EXT_IRQ_MASK: st_nxt.rdata = {st_r.irq_polarity, st_r.pin_irq_enable};
				`OFS_IRQ_STATUS:   st_nxt.rdata = {2'h0, st_r.irq_status};
				`OFS_IRQ_MASK:     st_nxt.rdata = {2'h0, st_r.irq_mask};
				`OFS_CORE_STATUS:  st_nxt.rdata = {st_r.global_ie, 7'h00};
				default:           st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_r                    <= '0;
			st_r.ext_mem_ctrl       <= `RST_EXT_MEM_CTRL;
			st_r.power_on_flag      <= `RST_POWER_ON_FLAG;
			st_r.pin_reset_flag     <= `RST_PIN_RESET_FLAG;
			st_r.sleep              <= SLP_AWAKE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA          = st_r.rdata;
	assign LATCH_WAIT     = {st_r.ext_mem_ctrl[`BIT_LATCH_WAIT_HI],
	                         st_r.ext_mem_ctrl[`BIT_LATCH_WAIT_LO]};
	assign LATCH_WAVEFORM = {st_r.ext_mem_ctrl[`BIT_LATCH_WAVE_HI],
	                         st_r.ext_mem_ctrl[`BIT_LATCH_WAVE_LO]};
	assign MEM_IF_MODE    = {st_r.ext_mem_ctrl[`BIT_MEM_IF_MODE_HI],
	                         st_r.ext_mem_ctrl[`BIT_MEM_IF_MODE_LO]};
	assign SLEEP_STATE    = st_r.sleep;
	assign CORE_CLK_STOP  = (st_r.sleep != SLP_AWAKE);
	assign OSC_STOP       = (st_r.sleep == SLP_POWER_DOWN);
	assign GLOBAL_IE      = st_r.global_ie;
	assign PIN_IRQ_REQ    = st_r.pin_irq_req;
	assign IRQ            = |(st_r.irq_status & st_r.irq_mask);

	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!rst_n);

	sequence enter_sleep_s;
		st_r.sleep == SLP_AWAKE && SLEEP_INSN && st_r.sleep_permit;
	endsequence
	sequence sleeping_s;
		st_r.sleep != SLP_AWAKE;
	endsequence

	AST_LATCH_WAIT: assert property (wr_hit_emc |=> LATCH_WAIT == $past(WDATA[7:6]))
		else $error("latch wait field not taken from write");
	AST_LATCH_WAVE: assert property (wr_hit_emc |=> LATCH_WAVEFORM == $past(WDATA[5:4]))
		else $error("latch waveform field not taken from write");
	AST_MEM_MODE: assert property (wr_hit_emc |=>
		MEM_IF_MODE == {$past(WDATA[0]), $past(WDATA[1])})
		else $error("memory interface mode bits misplaced");
	AST_NO_PERMIT: assert property (st_r.sleep == SLP_AWAKE && SLEEP_INSN &&
		!st_r.sleep_permit |=> !CORE_CLK_STOP)
		else $error("slept without permission");
	AST_IDLE: assert property (enter_sleep_s ##0 !st_r.sleep_depth_select |=>
		CORE_CLK_STOP && !OSC_STOP)
		else $error("shallow sleep wrong");
	AST_PDOWN: assert property (enter_sleep_s ##0 st_r.sleep_depth_select |=>
		OSC_STOP && CORE_CLK_STOP)
		else $error("deep sleep wrong");
	AST_WAKE: assert property (sleeping_s ##0 wake |=> !CORE_CLK_STOP ##1 1'b1)
		else $error("no wake on enabled event");
	AST_TAP: assert property (st_r.sleep == SLP_POWER_DOWN && TAP_ACTIVITY &&
		!wake |=> SLEEP_STATE == SLP_STANDBY && !OSC_STOP)
		else $error("tap activity did not leave deep sleep");
	AST_PIN_RST: assert property (PIN_RESET_SEEN |=> st_r.pin_reset_flag &&
		($stable(st_r.power_on_flag) || $past(wr_hit_rst)))
		else $error("pin reset flag not set");
	AST_WDOG: assert property (WATCHDOG_RESET_SEEN && !wr_hit_rst && !PIN_RESET_SEEN
		|=> $stable(st_r.power_on_flag) && $stable(st_r.pin_reset_flag))
		else $error("watchdog reset changed a flag");
	AST_PIN_REQ: assert property (1'b1 |=> PIN_IRQ_REQ ==
		($past(PIN_IRQ ^ st_r.irq_polarity) & $past(st_r.pin_irq_enable) &
		 {4{$past(st_r.global_ie)}}))
		else $error("pin request gating wrong");
	AST_GIE: assert property (IRQ_TAKEN && !RETURN_FROM_IRQ_INSTRUCTION |=> !GLOBAL_IE)
		else $error("global enable not cleared on entry");
	AST_GIE_SET: assert property (RETURN_FROM_IRQ_INSTRUCTION |=> GLOBAL_IE)
		else $error("global enable not set on return");

	sequence awake_s;
		st_r.sleep == SLP_AWAKE;
	endsequence
	sequence pdown_s;
		st_r.sleep == SLP_POWER_DOWN;
	endsequence
	sequence standby_s;
		st_r.sleep == SLP_STANDBY;
	endsequence

	// sleep sequencing checks
	AST_STAY_ASLEEP: assert property (sleeping_s ##0 !(|pin_enabled) &&
		!(USB_CORE_ACTIVE && USB_BUS_ACTIVITY) && !TAP_ACTIVITY |=> sleeping_s)
		else $error("left sleep with no wake source");
	AST_SLEEP_ONCE: assert property (sleeping_s ##0 SLEEP_INSN && !wake &&
		!TAP_ACTIVITY |=> $stable(SLEEP_STATE))
		else $error("sleep instruction acted while asleep");
	AST_TAP_IDLE: assert property (st_r.sleep == SLP_IDLE && TAP_ACTIVITY && !wake
		|=> SLEEP_STATE == SLP_IDLE)
		else $error("tap activity moved shallow sleep");
	AST_WAKE_FIRST: assert property (pdown_s ##0 wake && TAP_ACTIVITY |=>
		awake_s)
		else $error("wake lost to tap activity");
	AST_CLK_STANDBY: assert property (standby_s |-> CORE_CLK_STOP && !OSC_STOP)
		else $error("stand-by clock controls wrong");
	AST_WAKE_EVT: assert property (sleeping_s ##1 awake_s |->
		st_r.irq_status[`IRQ_EVT_WAKE])
		else $error("wake event not recorded");
	AST_STANDBY_EVT: assert property (pdown_s ##1 standby_s |->
		st_r.irq_status[`IRQ_EVT_STANDBY])
		else $error("stand-by event not recorded");

	// reset flag checks
	AST_POR_HOLD: assert property (!wr_hit_rst |=> $stable(st_r.power_on_flag))
		else $error("power-on flag changed without a write");
	AST_PIN_FLAG_HOLD: assert property (!wr_hit_rst && !PIN_RESET_SEEN |=>
		$stable(st_r.pin_reset_flag))
		else $error("pin reset flag changed without cause");

	// register write checks
	AST_WR_SLEEP: assert property (wr_hit_slp |=>
		st_r.sleep_permit == $past(WDATA[`BIT_SLEEP_PERMIT]) &&
		st_r.sleep_depth_select == $past(WDATA[`BIT_SLEEP_DEPTH]))
		else $error("sleep control not taken from write");
	AST_WR_POL: assert property (wr_hit_eim |=>
		st_r.irq_polarity == $past(WDATA[7:4]))
		else $error("polarity bits not taken from write");

	// read-back checks
	AST_RD_MEM: assert property (RD_STB && ADDR == `OFS_EXT_MEM_CTRL |=>
		RDATA == $past(st_r.ext_mem_ctrl))
		else $error("memory interface control read back wrong");
	AST_RD_FLAGS: assert property (RD_STB && ADDR == `OFS_RESET_SRC |=>
		RDATA == {6'h00, $past(st_r.pin_reset_flag), $past(st_r.power_on_flag)})
		else $error("reset flags read back wrong");
	AST_RD_SLEEP: assert property (RD_STB && ADDR == `OFS_SLEEP_CTRL |=>
		RDATA[`BIT_SLEEP_PERMIT] == $past(st_r.sleep_permit) &&
		RDATA[`BIT_SLEEP_DEPTH] == $past(st_r.sleep_depth_select))
		else $error("sleep control read back wrong");
	AST_RD_EIM: assert property (RD_STB && ADDR == `OFS_EXT_IRQ_MASK |=>
		RDATA == {$past(st_r.irq_polarity), $past(st_r.pin_irq_enable)})
		else $error("pin interrupt register read back wrong");
	AST_RD_GIE: assert property (RD_STB && ADDR == `OFS_CORE_STATUS |=>
		RDATA[`BIT_GLOBAL_IE] == $past(st_r.global_ie))
		else $error("global enable read back wrong");
	AST_RD_STATUS: assert property (RD_STB && ADDR == `OFS_IRQ_STATUS |=>
		RDATA == {2'h0, $past(st_r.irq_status)})
		else $error("event status read back wrong");
endmodule // sysctl_regs

// >>> rtl/sysctl_cfg.svh
// offsets, field positions, reset values of the system control registers
`ifndef SYSCTL_CFG_SVH
`define SYSCTL_CFG_SVH
`define ADDR_W           6
`define OFS_EXT_MEM_CTRL 6'h1D
`define OFS_RESET_SRC    6'h34
`define OFS_SLEEP_CTRL   6'h35
`define OFS_EXT_IRQ_MASK 6'h37
`define OFS_IRQ_STATUS   6'h38
`define OFS_IRQ_MASK     6'h39
`define OFS_CORE_STATUS  6'h3F
`define BIT_LATCH_WAIT_HI   7
`define BIT_LATCH_WAIT_LO   6
`define BIT_LATCH_WAVE_HI   5
`define BIT_LATCH_WAVE_LO   4
`define BIT_MEM_IF_MODE_LO  1
`define BIT_MEM_IF_MODE_HI  0
`define BIT_SLEEP_PERMIT    6
`define BIT_SLEEP_DEPTH     5
`define BIT_PIN_RESET_FLAG  1
`define BIT_POWER_ON_FLAG   0
`define BIT_GLOBAL_IE       7
`define RST_EXT_MEM_CTRL    8'h00
`define RST_EXT_IRQ_MASK    8'h00
`define RST_POWER_ON_FLAG   1'b1
`define RST_PIN_RESET_FLAG  1'b0
`define IRQ_EVT_W           6
`define IRQ_EVT_WAKE        4
`define IRQ_EVT_STANDBY     5
`endif

// >>> rtl/sysctl_pkg.sv
// types of the system control register bank
package sysctl_pkg;
	typedef enum logic [1:0] {SLP_AWAKE, SLP_IDLE, SLP_POWER_DOWN, SLP_STANDBY} sleep_e;
	typedef struct packed {
		logic [7:0] ext_mem_ctrl;
		logic       sleep_permit;
		logic       sleep_depth_select;
		logic       power_on_flag;
		logic       pin_reset_flag;
		logic [3:0] irq_polarity;
		logic [3:0] pin_irq_enable;
		logic       global_ie;
		logic [5:0] irq_status;
		logic [5:0] irq_mask;
		sleep_e     sleep;
		logic [3:0] pin_irq_req;
		logic [7:0] rdata;
	} state_s;
endpackage

// >>> test/mcu_system_control_regs_test.sv
// self-checking bench of the system control register bank
`include "sysctl_cfg.svh"
module mcu_system_control_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] P_SLP  = 5'h10;
	localparam logic [4:0] P_TKN  = 5'h08;
	localparam logic [4:0] P_RETURN_FROM_IRQ_INSTRUCTION = 5'h04;
	localparam logic [4:0] P_PIN  = 5'h02;
	localparam logic [4:0] P_WDOG = 5'h01;
	logic       clk      = 1'b0;
	logic       arst_n   = 1'b0;
	logic [5:0] addr     = 6'h00;
	logic [7:0] wdata    = 8'h00;
	logic       wr_stb   = 1'b0;
	logic       rd_stb   = 1'b0;
	logic [4:0] pls      = 5'h00;
	logic [3:0] pin_irq  = 4'h0;
	logic       usb_on   = 1'b0;
	logic       usb_act  = 1'b0;
	logic       tap      = 1'b0;
	logic [7:0] rdata;
	logic [1:0] wait_q;
	logic [1:0] wave_q;
	logic [1:0] mode_q;
	logic [1:0] state_q;
	logic       clk_stop;
	logic       osc_stop;
	logic       gie;
	logic       irq;
	logic [3:0] req;
	int         err_count = 0;
	int         cmp_count = 0;

	sysctl_regs dut_u (
		.SYS_CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .SLEEP_INSN(pls[4]),
		.IRQ_TAKEN(pls[3]), .RETURN_FROM_IRQ_INSTRUCTION(pls[2]),
		.PIN_RESET_SEEN(pls[1]), .WATCHDOG_RESET_SEEN(pls[0]), .PIN_IRQ(pin_irq),
		.USB_CORE_ACTIVE(usb_on), .USB_BUS_ACTIVITY(usb_act), .TAP_ACTIVITY(tap),
		.LATCH_WAIT(wait_q), .LATCH_WAVEFORM(wave_q), .MEM_IF_MODE(mode_q),
		.SLEEP_STATE(state_q), .CORE_CLK_STOP(clk_stop), .OSC_STOP(osc_stop),
		.GLOBAL_IE(gie), .PIN_IRQ_REQ(req), .IRQ(irq)
	);

	always #20 clk = ~clk;

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_stb <= 1'b1;
		addr   <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		chk("rdata", exp, rdata);
	endtask

	task automatic pulse(input logic [4:0] v);
		@(posedge clk);
		pls <= v;
		@(posedge clk);
		pls <= 5'h00;
		@(negedge clk);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk_slp(input logic [7:0] exp);
		chk("sleep", exp, {4'h0, state_q, clk_stop, osc_stop});
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`OFS_RESET_SRC, 8'h01);
		rd(`OFS_EXT_MEM_CTRL, 8'h00);
		rd(`OFS_EXT_IRQ_MASK, 8'h00);
		wr(`OFS_EXT_MEM_CTRL, 8'h6D);
		@(negedge clk);
		chk("mem", 8'h1A, {2'h0, wait_q, wave_q, mode_q});
		rd(`OFS_EXT_MEM_CTRL, 8'h6D);
		wr(`OFS_EXT_MEM_CTRL, 8'h92);
		@(negedge clk);
		chk("mem", 8'h25, {2'h0, wait_q, wave_q, mode_q});
		pulse(P_PIN);
		rd(`OFS_RESET_SRC, 8'h03);
		wr(`OFS_RESET_SRC, 8'h00);
		rd(`OFS_RESET_SRC, 8'h00);
		pulse(P_WDOG);
		rd(`OFS_RESET_SRC, 8'h00);
		pulse(P_PIN);
		rd(`OFS_RESET_SRC, 8'h02);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr   <= `OFS_RESET_SRC;
		wdata  <= 8'h01;
		pls    <= P_PIN;
		@(posedge clk);
		wr_stb <= 1'b0;
		pls    <= 5'h00;
		rd(`OFS_RESET_SRC, 8'h03);
		wr(`OFS_CORE_STATUS, 8'h80);
		rd(`OFS_CORE_STATUS, 8'h80);
		wr(`OFS_EXT_IRQ_MASK, 8'h5F);
		rd(`OFS_EXT_IRQ_MASK, 8'h5F);
		idle(2);
		chk("req", 8'h05, {4'h0, req});
		@(posedge clk);
		pin_irq <= 4'hF;
		idle(3);
		chk("req", 8'h0A, {4'h0, req});
		pulse(P_TKN);
		chk("gie", 8'h00, {7'h00, gie});
		idle(2);
		chk("req", 8'h00, {4'h0, req});
		pulse(P_RETURN_FROM_IRQ_INSTRUCTION);
		chk("gie", 8'h01, {7'h00, gie});
		wr(`OFS_EXT_IRQ_MASK, 8'h02);
		idle(3);
		chk("req", 8'h02, {4'h0, req});
		rd(`OFS_IRQ_STATUS, 8'h0F);
		chk("irq", 8'h00, {7'h00, irq});
		wr(`OFS_IRQ_MASK, 8'h02);
		idle(2);
		chk("irq", 8'h01, {7'h00, irq});
		wr(`OFS_IRQ_STATUS, 8'h0F);
		rd(`OFS_IRQ_STATUS, 8'h02);
		@(posedge clk);
		pin_irq <= 4'h0;
		idle(3);
		wr(`OFS_IRQ_STATUS, 8'h3F);
		idle(2);
		chk("irq", 8'h00, {7'h00, irq});
		pulse(P_SLP);
		chk_slp(8'h00);
		wr(`OFS_SLEEP_CTRL, 8'h40);
		pulse(P_SLP);
		chk_slp(8'h06);
		@(posedge clk);
		usb_act <= 1'b1;
		idle(2);
		chk_slp(8'h06);
		@(posedge clk);
		usb_on <= 1'b1;
		idle(2);
		chk_slp(8'h00);
		@(posedge clk);
		usb_on  <= 1'b0;
		usb_act <= 1'b0;
		wr(`OFS_SLEEP_CTRL, 8'h60);
		rd(`OFS_SLEEP_CTRL, 8'h60);
		pulse(P_SLP);
		chk_slp(8'h0B);
		@(posedge clk);
		tap <= 1'b1;
		@(posedge clk);
		tap <= 1'b0;
		idle(1);
		chk_slp(8'h0E);
		@(posedge clk);
		pin_irq <= 4'h2;
		idle(3);
		chk_slp(8'h00);
		rd(`OFS_IRQ_STATUS, 8'h32);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`OFS_RESET_SRC, 8'h01);
		chk("gie", 8'h00, {7'h00, gie});
		final_report();
	end

	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		final_report();
	end
endmodule // mcu_system_control_regs_test
